// file: rtl/ulbs_pkg.sv
// Constants, field layout and types of the LIN-capable serial channel.
// Assumes one 10 MHz system clock and a plain register port.
//
// Overview of operation
// - Break receive flag is 1 during break reception; cleared when power and receive are both off, or on success.
// - A short break keeps the flag set and rearms break reception.
// - Writing 1 to break receive trigger arms break reception; it reads 0.
// - Writing 1 to break transmit trigger starts a break field; it reads 0.
// - Break length field selects 13 to 20 low bits, 13 by default.
// - Output inversion bit inverts the serial output pin level.
// - Input inversion bit inverts the input; changed only with receiver off; the code takes option writes to it at any time.
// - Error flags clear on writing 0, keep value on 1; busy is read-only.
// - Reset or power off zero status; transmit/receive disable clear their flags.
// - Transmit holding write sets busy; busy clears when no further data follows.
// - Parity error flag sets when received parity disagrees with odd or even selection; zero parity is not checked.
// - Framing error flag sets when the first stop bit is low.
// - Reception over unread data sets overrun and discards the new byte.
// - Seven-bit data sits in bits 6..0 LSB-first, 7..1 MSB-first.
// - Receive holding is read-only, all ones on reset and power off.
// - Transmit holding is read/write with reset value all ones.
// - Holding write starts transmission; moving to shifter raises transmit-ready event.
// - Break of 11 or more bits ends normally with receive-done event.
// - After a break field the transmit trigger clears itself.
package ulbs_pkg;
  localparam int ADDR_W = 28;
  localparam logic [27:0] OFS_CTRL = 28'hffffa00;
  localparam logic [27:0] OFS_OPT = 28'hffffa03;
  localparam logic [27:0] OFS_STAT = 28'hffffa04;
  localparam logic [27:0] OFS_RXD = 28'hffffa05;
  localparam logic [27:0] OFS_TXD = 28'hffffa06;
  localparam logic [7:0] CTRL_RST = 8'h10;
  localparam logic [7:0] OPT_RST = 8'h14;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] RXD_RST = 8'hff;
  localparam logic [7:0] TXD_RST = 8'hff;
  localparam int OPT_SRF = 7;
  localparam int OPT_SRT = 6;
  localparam int OPT_STT = 5;
  localparam int OPT_SLS = 2;
  localparam int OPT_TDL = 1;
  localparam int OPT_RDL = 0;
  localparam int STAT_TSF = 7;
  localparam int STAT_PE = 2;
  localparam int STAT_FE = 1;
  localparam int STAT_OVE = 0;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [4:0] BRK_BASE = 5'h0d;
  localparam logic [2:0] BRK_SEL_OFS = 3'h3;
  localparam logic [4:0] BRK_MIN = 5'h0b;
  localparam logic [4:0] BRK_SAT = 5'h1f;
  localparam int CLK_NS = 100;
  localparam int BIT_NS = 1600;
  localparam int BIT_CYC_I = (BIT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] BIT_CYC = BIT_CYC_I[7:0];
  localparam logic [7:0] HALF_CYC = BIT_CYC >> 1;

  typedef struct packed {
    logic unit_power_enable;
    logic transmit_enable;
    logic receive_enable;
    logic lsb_first;
    logic [1:0] parity_sel;
    logic char_8bit;
    logic stop_length_sel;
  } ulbs_ctrl_s;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h0, TX_START = 3'h1, TX_DATA = 3'h2,
    TX_PAR = 3'h3, TX_STOP = 3'h4, TX_BRK = 3'h5
  } ulbs_tx_e;

  typedef enum logic [2:0] {
    RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h2,
    RX_PAR = 3'h3, RX_STOP = 3'h4, RX_BRK = 3'h5
  } ulbs_rx_e;
endpackage

// file: rtl/ulbs_sync2.sv
// Two-stage synchroniser for the serial input pin.
// Assumes the pin is asynchronous to the system clock.
`timescale 1ns/1ps
`default_nettype none
module ulbs_sync2 (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_async,
  output logic o_sync
);
  logic meta_q;
  logic sync_q;

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule
`default_nettype wire

// file: rtl/ulbs_tick.sv
// Bit-period enable divider with reload on restart.
// Assumes the system clock; tick is a one-cycle enable.
`timescale 1ns/1ps
`default_nettype none
module ulbs_tick (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_restart,
  input wire logic [7:0] i_load,
  output logic o_tick
);
  logic [7:0] cnt_q;

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n || i_restart) begin
      cnt_q <= i_reset_n ? i_load : 8'h00;
    end else if (cnt_q == ulbs_pkg::BIT_CYC - 8'h01) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  assign o_tick = !i_restart && (cnt_q == ulbs_pkg::BIT_CYC - 8'h01);
endmodule
`default_nettype wire

// file: rtl/ulbs_top.sv
// One serial channel with break field send/receive and status flags.
// Assumes a register port on the system clock and an asynchronous pin.
`timescale 1ns/1ps
`default_nettype none
module ulbs_top (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic [27:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [7:0] o_rd_data,
  input wire logic i_serial_in_pin,
  output logic o_serial_out_pin,
  output logic o_rx_done_irq,
  output logic o_tx_ready_irq
);
  logic [7:0] ctrl_q;
  ulbs_pkg::ulbs_ctrl_s ctl;
  logic wr_ctrl;
  logic wr_opt;
  logic wr_stat;
  logic wr_txd;
  logic rd_rxd;
  logic pwr;
  logic tx_en;
  logic rx_en;
  logic srf_q;
  logic stt_q;
  logic [2:0] sls_q;
  logic tdl_q;
  logic rdl_q;
  logic tsf_q;
  logic pe_q;
  logic fe_q;
  logic ove_q;
  logic [7:0] txd_q;
  logic [7:0] rxd_q;
  logic unread_q;
  logic [7:0] rd_q;
  ulbs_pkg::ulbs_tx_e tx_st_q;
  logic [7:0] tsr_q;
  logic [4:0] tcnt_q;
  logic tpar_q;
  logic tx_pend_q;
  logic tx_tick;
  logic tx_line;
  logic tx_irq_q;
  logic tx_done;
  logic brk_tx_done;
  logic [4:0] brk_len;
  logic [2:0] brk_code;
  logic [7:0] tx_mask;
  logic [4:0] nbits;
  logic serial_q;
  ulbs_pkg::ulbs_rx_e rx_st_q;
  logic rx_sync;
  logic rx_in;
  logic rx_prev_q;
  logic rx_tick;
  logic [7:0] rsr_q;
  logic [7:0] rx_align;
  logic [4:0] rcnt_q;
  logic rpar_q;
  logic rx_done;
  logic rx_pe;
  logic rx_fe;
  logic brk_ok;
  logic rx_irq_q;

  assign ctl = ulbs_pkg::ulbs_ctrl_s'(ctrl_q);
  assign pwr = ctl.unit_power_enable;
  assign tx_en = pwr && ctl.transmit_enable;
  assign rx_en = pwr && ctl.receive_enable;
  assign wr_ctrl = i_wr_en && (i_addr == ulbs_pkg::OFS_CTRL);
  assign wr_opt = i_wr_en && (i_addr == ulbs_pkg::OFS_OPT);
  assign wr_stat = i_wr_en && (i_addr == ulbs_pkg::OFS_STAT);
  assign wr_txd = i_wr_en && (i_addr == ulbs_pkg::OFS_TXD);
  assign rd_rxd = i_rd_en && (i_addr == ulbs_pkg::OFS_RXD);
  assign nbits = ctl.char_8bit ? 5'h08 : 5'h07;

  // Control register
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      ctrl_q <= ulbs_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= i_wr_data;
    end
  end

  // Option fields written directly
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      sls_q <= ulbs_pkg::OPT_RST[ulbs_pkg::OPT_SLS +: 3];
      tdl_q <= ulbs_pkg::OPT_RST[ulbs_pkg::OPT_TDL];
      rdl_q <= ulbs_pkg::OPT_RST[ulbs_pkg::OPT_RDL];
    end else if (wr_opt) begin
      sls_q <= i_wr_data[ulbs_pkg::OPT_SLS +: 3];
      tdl_q <= i_wr_data[ulbs_pkg::OPT_TDL];
      rdl_q <= i_wr_data[ulbs_pkg::OPT_RDL];
    end
  end

  // Break receive flag
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      srf_q <= 1'b0;
    end else if (!pwr && !ctl.receive_enable) begin
      srf_q <= 1'b0;
    end else if (wr_opt && i_wr_data[ulbs_pkg::OPT_SRT]) begin
      srf_q <= 1'b1;
    end else if (brk_ok) begin
      srf_q <= 1'b0;
    end
  end

  // Break transmit trigger
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n || !tx_en) begin
      stt_q <= 1'b0;
    end else if (wr_opt && i_wr_data[ulbs_pkg::OPT_STT]) begin
      stt_q <= 1'b1;
    end else if (brk_tx_done) begin
      stt_q <= 1'b0;
    end
  end

  // Status flags, hardware set wins over software clear
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n || !pwr) begin
      tsf_q <= 1'b0;
      pe_q <= 1'b0;
      fe_q <= 1'b0;
      ove_q <= 1'b0;
    end else begin
      if (!ctl.transmit_enable) begin
        tsf_q <= 1'b0;
      end else if (wr_txd) begin
        tsf_q <= 1'b1;
      end else if (tx_done && !tx_pend_q) begin
        tsf_q <= 1'b0;
      end
      if (!ctl.receive_enable) begin
        pe_q <= 1'b0;
        fe_q <= 1'b0;
        ove_q <= 1'b0;
      end else begin
        pe_q <= (rx_done && rx_pe) ||
          (pe_q && !(wr_stat && !i_wr_data[ulbs_pkg::STAT_PE]));
        fe_q <= (rx_done && rx_fe) ||
          (fe_q && !(wr_stat && !i_wr_data[ulbs_pkg::STAT_FE]));
        ove_q <= (rx_done && unread_q) ||
          (ove_q && !(wr_stat && !i_wr_data[ulbs_pkg::STAT_OVE]));
      end
    end
  end

  // Transmit holding register
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      txd_q <= ulbs_pkg::TXD_RST;
    end else if (wr_txd) begin
      txd_q <= i_wr_data;
    end
  end

  // Pending transmit data
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n || !tx_en) begin
      tx_pend_q <= 1'b0;
    end else if (wr_txd) begin
      tx_pend_q <= 1'b1;
    end else if (tx_st_q == ulbs_pkg::TX_IDLE && !stt_q) begin
      tx_pend_q <= 1'b0;
    end
  end

  assign tx_mask = ctl.char_8bit ? txd_q :
    (ctl.lsb_first ? {1'b0, txd_q[6:0]} : {txd_q[7:1], 1'b0});
  assign brk_code = sls_q + ulbs_pkg::BRK_SEL_OFS;
  assign brk_len = ulbs_pkg::BRK_BASE + {2'b00, brk_code};
  assign tx_done = tx_tick && tx_st_q == ulbs_pkg::TX_STOP &&
    tcnt_q == {4'h0, ctl.stop_length_sel};
  assign brk_tx_done = tx_tick && tx_st_q == ulbs_pkg::TX_BRK &&
    tcnt_q == brk_len - 5'h01;

  ulbs_tick u_tx_tick (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_restart(tx_st_q == ulbs_pkg::TX_IDLE),
    .i_load(8'h00),
    .o_tick(tx_tick)
  );

  // Transmit sequencer
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n || !tx_en) begin
      tx_st_q <= ulbs_pkg::TX_IDLE;
      tsr_q <= 8'h00;
      tcnt_q <= 5'h00;
      tpar_q <= 1'b0;
    end else begin
      unique case (tx_st_q)
        ulbs_pkg::TX_IDLE: begin
          tcnt_q <= 5'h00;
          if (stt_q) begin
            tx_st_q <= ulbs_pkg::TX_BRK;
          end else if (tx_pend_q) begin
            tx_st_q <= ulbs_pkg::TX_START;
            tsr_q <= tx_mask;
            tpar_q <= (ctl.parity_sel == ulbs_pkg::PAR_ZERO) ? 1'b0 :
              (ctl.parity_sel == ulbs_pkg::PAR_ODD) ? ~^tx_mask : ^tx_mask;
          end
        end
        ulbs_pkg::TX_START: begin
          if (tx_tick) begin
            tx_st_q <= ulbs_pkg::TX_DATA;
          end
        end
        ulbs_pkg::TX_DATA: begin
          if (tx_tick) begin
            tsr_q <= ctl.lsb_first ? {1'b0, tsr_q[7:1]} : {tsr_q[6:0], 1'b0};
            tcnt_q <= tcnt_q + 5'h01;
            if (tcnt_q == nbits - 5'h01) begin
              tcnt_q <= 5'h00;
              tx_st_q <= (ctl.parity_sel == ulbs_pkg::PAR_NONE) ?
                ulbs_pkg::TX_STOP : ulbs_pkg::TX_PAR;
            end
          end
        end
        ulbs_pkg::TX_PAR: begin
          if (tx_tick) begin
            tx_st_q <= ulbs_pkg::TX_STOP;
          end
        end
        ulbs_pkg::TX_STOP: begin
          if (tx_tick) begin
            tcnt_q <= tcnt_q + 5'h01;
          end
          if (tx_done) begin
            tx_st_q <= ulbs_pkg::TX_IDLE;
          end
        end
        ulbs_pkg::TX_BRK: begin
          if (tx_tick) begin
            tcnt_q <= tcnt_q + 5'h01;
          end
          if (brk_tx_done) begin
            tx_st_q <= ulbs_pkg::TX_IDLE;
          end
        end
        default: begin
          tx_st_q <= ulbs_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // Transmit-ready event when data or a break enters the shifter
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n || !tx_en) begin
      tx_irq_q <= 1'b0;
    end else begin
      tx_irq_q <= tx_st_q == ulbs_pkg::TX_IDLE && (stt_q || tx_pend_q);
    end
  end

  always_comb begin
    unique case (tx_st_q)
      ulbs_pkg::TX_START: tx_line = 1'b0;
      ulbs_pkg::TX_DATA: tx_line = ctl.lsb_first ? tsr_q[0] : tsr_q[7];
      ulbs_pkg::TX_PAR: tx_line = tpar_q;
      ulbs_pkg::TX_BRK: tx_line = 1'b0;
      default: tx_line = 1'b1;
    endcase
  end

  // Serial output, idle high while powered down, then inverted if asked
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      serial_q <= 1'b1;
    end else begin
      serial_q <= (pwr ? tx_line : 1'b1) ^ tdl_q;
    end
  end

  ulbs_sync2 u_rx_sync (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_async(i_serial_in_pin),
    .o_sync(rx_sync)
  );

  assign rx_in = rx_sync ^ rdl_q;

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      rx_prev_q <= 1'b1;
    end else begin
      rx_prev_q <= rx_in;
    end
  end

  ulbs_tick u_rx_tick (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_restart(rx_st_q == ulbs_pkg::RX_IDLE),
    .i_load(ulbs_pkg::HALF_CYC),
    .o_tick(rx_tick)
  );

  assign rx_align = ctl.char_8bit ? rsr_q :
    (ctl.lsb_first ? {1'b0, rsr_q[7:1]} : {rsr_q[6:0], 1'b0});
  assign rx_done = rx_tick && rx_st_q == ulbs_pkg::RX_STOP;
  assign rx_fe = !rx_in;
  assign rx_pe = (ctl.parity_sel == ulbs_pkg::PAR_ODD) ?
    (rpar_q != ~^rx_align) :
    (ctl.parity_sel == ~ulbs_pkg::PAR_NONE) && (rpar_q != ^rx_align);
  assign brk_ok = rx_tick && rx_st_q == ulbs_pkg::RX_BRK && rx_in &&
    rcnt_q >= ulbs_pkg::BRK_MIN;

  // Receive sequencer
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n || !rx_en) begin
      rx_st_q <= ulbs_pkg::RX_IDLE;
      rsr_q <= 8'h00;
      rcnt_q <= 5'h00;
      rpar_q <= 1'b0;
    end else begin
      unique case (rx_st_q)
        ulbs_pkg::RX_IDLE: begin
          rcnt_q <= 5'h00;
          if (rx_prev_q && !rx_in) begin
            rx_st_q <= srf_q ? ulbs_pkg::RX_BRK : ulbs_pkg::RX_START;
          end
        end
        ulbs_pkg::RX_START: begin
          if (rx_tick) begin
            rx_st_q <= rx_in ? ulbs_pkg::RX_IDLE : ulbs_pkg::RX_DATA;
          end
        end
        ulbs_pkg::RX_DATA: begin
          if (rx_tick) begin
            rsr_q <= ctl.lsb_first ? {rx_in, rsr_q[7:1]} : {rsr_q[6:0], rx_in};
            rcnt_q <= rcnt_q + 5'h01;
            if (rcnt_q == nbits - 5'h01) begin
              rx_st_q <= (ctl.parity_sel == ulbs_pkg::PAR_NONE) ?
                ulbs_pkg::RX_STOP : ulbs_pkg::RX_PAR;
            end
          end
        end
        ulbs_pkg::RX_PAR: begin
          if (rx_tick) begin
            rpar_q <= rx_in;
            rx_st_q <= ulbs_pkg::RX_STOP;
          end
        end
        ulbs_pkg::RX_STOP: begin
          if (rx_tick) begin
            rx_st_q <= ulbs_pkg::RX_IDLE;
          end
        end
        ulbs_pkg::RX_BRK: begin
          if (rx_tick) begin
            if (rx_in) begin
              rx_st_q <= ulbs_pkg::RX_IDLE;
            end else if (rcnt_q != ulbs_pkg::BRK_SAT) begin
              rcnt_q <= rcnt_q + 5'h01;
            end
          end
        end
        default: begin
          rx_st_q <= ulbs_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // Receive holding register and unread marker
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n || !pwr) begin
      rxd_q <= ulbs_pkg::RXD_RST;
    end else if (rx_done && !unread_q) begin
      rxd_q <= rx_align;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n || !rx_en) begin
      unread_q <= 1'b0;
    end else if (rx_done) begin
      unread_q <= 1'b1;
    end else if (rd_rxd) begin
      unread_q <= 1'b0;
    end
  end

  // Receive-done event for a byte taken into the holding register or a good break
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n || !rx_en) begin
      rx_irq_q <= 1'b0;
    end else begin
      rx_irq_q <= (rx_done && !unread_q) || brk_ok;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      rd_q <= 8'h00;
    end else if (i_rd_en) begin
      unique case (i_addr)
        ulbs_pkg::OFS_CTRL: rd_q <= ctrl_q;
        ulbs_pkg::OFS_OPT: rd_q <= {srf_q, 2'b00, sls_q, tdl_q, rdl_q};
        ulbs_pkg::OFS_STAT: rd_q <= {tsf_q, 4'h0, pe_q, fe_q, ove_q};
        ulbs_pkg::OFS_RXD: rd_q <= rxd_q;
        ulbs_pkg::OFS_TXD: rd_q <= txd_q;
        default: rd_q <= 8'h00;
      endcase
    end else begin
      rd_q <= 8'h00;
    end
  end

  assign o_rd_data = rd_q;
  assign o_serial_out_pin = serial_q;
  assign o_rx_done_irq = rx_irq_q;
  assign o_tx_ready_irq = tx_irq_q;
endmodule
`default_nettype wire

// file: tb/ulbs_asserts.sv
// Port-level checks of one serial channel.
// Assumes binding into ulbs_top; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ulbs_asserts (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic [27:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] o_rd_data,
  input wire logic i_serial_in_pin,
  input wire logic o_serial_out_pin,
  input wire logic o_rx_done_irq,
  input wire logic o_tx_ready_irq
);
  ulbs_pkg::ulbs_ctrl_s ctrl_q;
  logic tdl_q;
  logic [1:0] quiet_q;
  logic rd_opt, rd_stat, rd_rxd, wr_txd, wr_brk, tx_on;
  assign rd_opt = i_rd_en && i_addr == ulbs_pkg::OFS_OPT;
  assign rd_stat = i_rd_en && i_addr == ulbs_pkg::OFS_STAT;
  assign rd_rxd = i_rd_en && i_addr == ulbs_pkg::OFS_RXD;
  assign tx_on = ctrl_q.unit_power_enable && ctrl_q.transmit_enable;
  assign wr_txd = i_wr_en && i_addr == ulbs_pkg::OFS_TXD && tx_on;
  assign wr_brk = i_wr_en && i_addr == ulbs_pkg::OFS_OPT && tx_on &&
                  i_wr_data[ulbs_pkg::OPT_STT];

  // Shadow of the control register
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      ctrl_q <= ulbs_pkg::ulbs_ctrl_s'(ulbs_pkg::CTRL_RST);
    end else if (i_wr_en && i_addr == ulbs_pkg::OFS_CTRL) begin
      ctrl_q <= ulbs_pkg::ulbs_ctrl_s'(i_wr_data);
    end
  end

  // Shadow of the output inversion bit
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      tdl_q <= ulbs_pkg::OPT_RST[ulbs_pkg::OPT_TDL];
    end else if (i_wr_en && i_addr == ulbs_pkg::OFS_OPT) begin
      tdl_q <= i_wr_data[ulbs_pkg::OPT_TDL];
    end
  end

  // Cycles since the last register write, saturating
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n || i_wr_en) begin
      quiet_q <= 2'h0;
    end else if (quiet_q != 2'h3) begin
      quiet_q <= quiet_q + 2'h1;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  chk_trig_read_zero: assert property (
    rd_opt |=> o_rd_data[6:5] == 2'h0) else $error("trigger read not 0");
  chk_stat_pad_zero: assert property (
    rd_stat |=> o_rd_data[6:3] == 4'h0) else $error("status pad not 0");
  chk_stat_off_zero: assert property (
    rd_stat && !ctrl_q.unit_power_enable && quiet_q == 2'h3
    |=> o_rd_data == 8'h00) else $error("status not 0 when off");
  chk_rxd_off_ones: assert property (
    rd_rxd && !ctrl_q.unit_power_enable && quiet_q == 2'h3
    |=> o_rd_data == 8'hff) else $error("rx holding not ff when off");
  chk_tx_load_event: assert property (
    wr_txd |-> ##[1:400] o_tx_ready_irq) else $error("no load event");
  chk_brk_start_event: assert property (
    wr_brk |-> ##[1:400] o_tx_ready_irq) else $error("no break event");
  chk_idle_level: assert property (
    !ctrl_q.unit_power_enable && quiet_q == 2'h3
    |-> o_serial_out_pin == !tdl_q) else $error("idle level wrong");
  chk_txirq_pulse: assert property (
    o_tx_ready_irq |=> !o_tx_ready_irq) else $error("tx event too long");
  chk_rx_off_quiet: assert property (
    !ctrl_q.receive_enable && quiet_q == 2'h3 |-> !o_rx_done_irq)
    else $error("rx event while receiver off");

  cov_rx_done: cover property (o_rx_done_irq);
  cov_break_tx: cover property (wr_brk ##[1:4] o_tx_ready_irq);
  cov_err_read: cover property (rd_stat ##1 o_rd_data[0]);
endmodule
bind ulbs_top ulbs_asserts u_ulbs_asserts (.i_sys_clk, .i_reset_n,
  .i_addr, .i_wr_data, .i_wr_en, .i_rd_en, .o_rd_data, .i_serial_in_pin,
  .o_serial_out_pin, .o_rx_done_irq, .o_tx_ready_irq);
`default_nettype wire

// file: tb/ulbs_remote.sv
// Remote serial node that drives the channel's input pin.
// Assumes the channel's bit time of BIT_CYC system clocks.
`timescale 1ns/1ps
`default_nettype none
module ulbs_remote (
  input wire logic i_sys_clk,
  output logic o_line
);
  logic idle_lvl = 1'b1;

  initial o_line = 1'b1;

  // Sets the level the line rests at between frames
  task automatic set_idle(input logic lvl);
    idle_lvl = lvl;
    o_line <= lvl;
  endtask

  // Sends n bits, first bit first, then rests one clock at idle
  task automatic send(input logic [31:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      o_line <= bits[i];
      repeat (ulbs_pkg::BIT_CYC) @(posedge i_sys_clk);
    end
    o_line <= idle_lvl;
    @(posedge i_sys_clk);
  endtask
endmodule
`default_nettype wire

// file: tb/ulbs_bench.sv
// Self-checking bench of one serial channel.
// Assumes ulbs_top, its checker and the remote node model.
`timescale 1ns/1ps
`default_nettype none
module ulbs_bench;
  localparam logic [27:0] CTL = ulbs_pkg::OFS_CTRL;
  localparam logic [27:0] OPT = ulbs_pkg::OFS_OPT;
  localparam logic [27:0] STA = ulbs_pkg::OFS_STAT;
  localparam logic [27:0] RXD = ulbs_pkg::OFS_RXD;
  localparam logic [27:0] TXD = ulbs_pkg::OFS_TXD;
  localparam logic [7:0] ON = 8'hf2;
  logic clk = 1'b0;
  logic rst_n, wen, ren, sin, sout, rxirq, txirq;
  logic [27:0] addr;
  logic [7:0] wdata, rdata;
  int errors = 0;
  int checked = 0;
  int rx_cnt = 0;

  ulbs_top u_ulbs_top (.i_sys_clk(clk), .i_reset_n(rst_n), .i_addr(addr),
    .i_wr_data(wdata), .i_wr_en(wen), .i_rd_en(ren), .o_rd_data(rdata),
    .i_serial_in_pin(sin), .o_serial_out_pin(sout),
    .o_rx_done_irq(rxirq), .o_tx_ready_irq(txirq));
  ulbs_remote u_ulbs_remote (.i_sys_clk(clk), .o_line(sin));

  always #50 clk = ~clk;
  always @(posedge clk) if (rxirq === 1'b1) rx_cnt++;

  task automatic complete_run;
    $display("Checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [27:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wen <= 1'b1;
    @(posedge clk);
    wen <= 1'b0;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cmp_n(input int got, input int exp);
    checked++;
    if (got != exp) begin
      errors++;
      $display("Error at %0t: count %0d want %0d", $time, got, exp);
    end
  endtask
  task automatic rcmp(input logic [27:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    ren <= 1'b1;
    @(posedge clk);
    ren <= 1'b0;
    #1;
    cmp(rdata, exp);
  endtask

  task automatic t_reset;
    rcmp(OPT, 8'h14);
    rcmp(TXD, 8'hff);
    rcmp(28'hffffa01, 8'h00);
    rcmp(STA, 8'h00);
    rcmp(RXD, 8'hff);
  endtask
  task automatic t_break_tx;
    int n;
    int w;
    logic act;
    for (int i = 0; i < 8; i++) begin
      act = i[0];
      wr(CTL, 8'h80);
      wr(OPT, {3'h0, 3'(i), act, 1'b0});
      wr(CTL, ON);
      wr(OPT, {3'h1, 3'(i), act, 1'b0});
      n = 0;
      w = 0;
      while (sout !== act && w < 40) begin w++; step; end
      while (sout === act && n < 400) begin n++; step; end
      cmp_n(n, 16 * (13 + (i + 3) % 8));
      rcmp(OPT, {3'h0, 3'(i), act, 1'b0});
    end
  endtask
  task automatic t_tx_byte;
    logic [9:0] f;
    int w;
    wr(CTL, 8'h80);
    wr(OPT, 8'h14);
    wr(CTL, ON);
    wr(TXD, 8'h5a);
    rcmp(STA, 8'h80);
    rcmp(TXD, 8'h5a);
    w = 0;
    while (sout !== 1'b0 && w < 40) begin w++; step; end
    repeat (8) step;
    for (int j = 0; j < 10; j++) begin
      f[j] = sout;
      repeat (16) step;
    end
    cmp(f[8:1], 8'h5a);
    cmp({6'h0, f[9], f[0]}, 8'h02);
    rcmp(STA, 8'h00);
  endtask
  task automatic t_rx_bytes;
    u_ulbs_remote.send({1'b1, 8'ha5, 1'b0}, 10);
    rcmp(RXD, 8'ha5);
    u_ulbs_remote.send({1'b1, 8'h3c, 1'b0}, 10);
    u_ulbs_remote.send({1'b1, 8'h0f, 1'b0}, 10);
    rcmp(STA, 8'h01);
    rcmp(RXD, 8'h3c);
    wr(STA, 8'hff);
    rcmp(STA, 8'h01);
    wr(STA, 8'h00);
    rcmp(STA, 8'h00);
    u_ulbs_remote.send({1'b0, 8'h11, 1'b0}, 10);
    rcmp(STA, 8'h02);
    wr(CTL, 8'h80);
    rcmp(STA, 8'h00);
    wr(CTL, 8'hfa);
    u_ulbs_remote.send({2'h3, 8'h01, 1'b0}, 11);
    rcmp(STA, 8'h04);
  endtask
  task automatic t_seven_bit;
    wr(CTL, 8'h80);
    wr(CTL, 8'ha0);
    u_ulbs_remote.send({1'b1, 7'h5d, 1'b0}, 9);
    rcmp(RXD, 8'hba);
    wr(CTL, 8'h80);
    wr(CTL, 8'hb0);
    u_ulbs_remote.send({1'b1, 7'h5d, 1'b0}, 9);
    rcmp(RXD, 8'h5d);
  endtask
  task automatic t_rx_invert;
    wr(CTL, 8'h80);
    wr(OPT, 8'h15);
    u_ulbs_remote.set_idle(1'b0);
    repeat (4) step;
    wr(CTL, 8'hb2);
    u_ulbs_remote.send(~{1'b1, 8'h96, 1'b0}, 10);
    rcmp(RXD, 8'h96);
    wr(CTL, 8'h80);
    wr(OPT, 8'h14);
    u_ulbs_remote.set_idle(1'b1);
    repeat (4) step;
  endtask
  task automatic t_break_rx;
    int c;
    wr(CTL, ON);
    wr(OPT, 8'h54);
    rcmp(OPT, 8'h94);
    c = rx_cnt;
    u_ulbs_remote.send(32'h0, 8);
    repeat (24) step;
    rcmp(OPT, 8'h94);
    cmp_n(rx_cnt, c);
    u_ulbs_remote.send(32'h0, 13);
    repeat (24) step;
    rcmp(OPT, 8'h14);
    cmp_n(rx_cnt, c + 1);
    wr(CTL, 8'h00);
    repeat (3) step;
    rcmp(STA, 8'h00);
    rcmp(RXD, 8'hff);
  endtask

  initial begin
    rst_n = 1'b0;
    wen = 1'b0;
    ren = 1'b0;
    addr = 28'h0;
    wdata = 8'h00;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_break_tx;
    t_tx_byte;
    t_rx_bytes;
    t_seven_bit;
    t_rx_invert;
    t_break_rx;
    complete_run;
  end
  initial begin
    #(30000 * 100);
    errors++;
    complete_run;
  end
endmodule
`default_nettype wire
